// ===== hw/gpt_timer_set.sv
// five 16-bit timers: one standalone plus two joinable pairs
// What this block does
// [R1] standalone timer: internal timer, synchronous counter, asynchronous external counter
// [R2] standalone flag on period match or on gate falling edge when gating
// [R3] software loads the standalone period before trusting match events
// [R4] sync bit picks synchronised or raw external clock; ignored on internal clock
// [R5] bit 15 run bit starts and stops each timer
// [R6] bits 5-4 prescale by 1, 8, 64 or 256
// [R7] bit 1 selects external pin rising edge, else internal peripheral clock
// [R8] bit 6 gate accumulation works only with internal clock
// [R9] bit 13 halts timer while cpu idle
// [R10] writing control while running resets the prescale counter
// [R11] unimplemented control bits read zero
// [R12] lower bit 3 joins pair into one 32-bit timer
// [R13] in joined mode upper control bits have no effect
// [R14] joined match raises the upper timer flag only
// [R15] joined count: upper holds high word, lower low word
// [R16] joined period: upper period high word, lower period low word
// [R17] pair timers run only synchronous, never asynchronous counting
// [R18] converter trigger only from first pair joined, or its upper timer
// [R19] on match count restarts at zero on next count clock
// [R20] gated accumulation counts only while gate is high
`timescale 1ns/1ps
`include "gpt_cfg.svh"

module gpt_timer_set
  import gpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpu_idle,
  input wire logic [2:0] ext_clock_pin,
  input wire logic [`GPT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [4:0] event_flags,
  output logic conv_trigger
);

  gpt_state_t s_reg;
  gpt_state_t s_next;

  // mask of implemented bits for control register index i
  function automatic logic [15:0] con_mask(input int i);
    if (i == 0)
      con_mask = `GPT_MASK_STANDALONE;
    else if (i == 1 || i == 3)
      con_mask = `GPT_MASK_LOWER;
    else
      con_mask = `GPT_MASK_UPPER;
  endfunction

  // prescale terminal count for the 2-bit field
  function automatic logic [7:0] pre_top(input logic [1:0] ps);
    case (ps)
      2'b00: pre_top = 8'h00;
      2'b01: pre_top = 8'h07;
      2'b10: pre_top = 8'h3f;
      default: pre_top = 8'hff;
    endcase
  endfunction

  // external clock for timer i: pin 0 standalone, 1 first pair, 2 second pair
  function automatic int pin_of(input int i);
    if (i == 0)
      pin_of = 0;
    else if (i < 3)
      pin_of = 1;
    else
      pin_of = 2;
  endfunction

  logic bus_hit;
  logic wr_fire;
  logic rd_fire;
  assign bus_hit = (avs_read || avs_write) && (s_reg.bus_st == GPT_BUS_IDLE);
  // writes land at the answering edge, the one where the master sees waitrequest low
  assign wr_fire = avs_write && (s_reg.bus_st == GPT_BUS_ACK);
  assign rd_fire = avs_read && bus_hit;

  // one wait state: request taken in idle, answered in ack
  assign avs_waitrequest = (avs_read || avs_write) && (s_reg.bus_st != GPT_BUS_ACK);
  assign avs_readdata = s_reg.rdata;
  assign event_flags = s_reg.flag;

  // trigger pulses when the first pair upper flag position fires
  logic [4:0] match_ev;
  assign conv_trigger = match_ev[2]; // R18

  // per timer combinational terms
  logic [4:0] running;
  logic [4:0] tick_src;
  logic [4:0] pre_wrap;
  logic [4:0] gate_fall;
  logic join_a;
  logic join_b;
  assign join_a = s_reg.tmr[1].con[`GPT_BIT_JOIN]; // R12
  assign join_b = s_reg.tmr[3].con[`GPT_BIT_JOIN]; // R12

  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_tmr
      // governing control: the lower timer owns the pair when joined
      logic [15:0] gc;
      logic is_slave;
      logic ext_edge;
      logic gate_lvl;
      assign is_slave = (g == 2 && join_a) || (g == 4 && join_b);
      assign gc = is_slave ? s_reg.tmr[g-1].con : s_reg.tmr[g].con; // R13
      // pair timers always take the synchronised edge; standalone may use the raw one
      assign ext_edge = (g == 0 && !gc[`GPT_BIT_SYNC]) ? // R4 R17
        (s_reg.ext_sync1[0] && !s_reg.ext_d[0]) :
        (s_reg.ext_sync2[pin_of(g)] && !s_reg.ext_d[pin_of(g)]);
      assign gate_lvl = s_reg.ext_sync2[pin_of(g)];
      assign running[g] = gc[`GPT_BIT_RUN] && !(gc[`GPT_BIT_IDLE] && cpu_idle); // R5 R9
      assign tick_src[g] = gc[`GPT_BIT_CS] ? ext_edge : // R7 R1
        (gc[`GPT_BIT_GATE] ? gate_lvl : 1'b1); // R8 R20
      // at or past the top: a stale count left from a larger ratio must not lose ticks
      assign pre_wrap[g] = running[g] && tick_src[g] && (s_reg.tmr[g].pre >= pre_top(gc[5:4])); // R6
      assign gate_fall[g] = running[g] && !gc[`GPT_BIT_CS] && gc[`GPT_BIT_GATE]
        && s_reg.tmr[g].gate_d && !gate_lvl; // R2
    end
  endgenerate

  // next-state logic for timers, bus and flags
  always_comb
  begin
    logic [31:0] cnt32;
    logic [31:0] per32;
    logic [15:0] wd;
    int k;
    s_next = s_reg;
    match_ev = 5'h00;
    cnt32 = 32'h0;
    per32 = 32'h0;
    wd = avs_writedata[15:0];
    k = 0;
    // synchronisers: first stage feeds the second, and the standalone raw edge when sync is clear
    s_next.ext_sync1 = ext_clock_pin;
    s_next.ext_sync2 = s_reg.ext_sync1;
    s_next.ext_d = s_reg.ext_sync2;
    s_next.ext_d[0] = s_reg.tmr[0].con[`GPT_BIT_SYNC] ? s_reg.ext_sync2[0] : s_reg.ext_sync1[0]; // R4
    // prescalers and 16-bit counting
    for (int i = 0; i < 5; i++)
    begin
      s_next.tmr[i].gate_d = s_reg.ext_sync2[pin_of(i)];
      if (running[i] && tick_src[i])
        s_next.tmr[i].pre = pre_wrap[i] ? 8'h00 : s_reg.tmr[i].pre + 8'h01;
      if (!((i == 2 && join_a) || (i == 4 && join_b) || (i == 1 && join_a) || (i == 3 && join_b)))
      begin
        if (pre_wrap[i])
        begin
          if (s_reg.tmr[i].cnt == s_reg.tmr[i].per)
          begin
            s_next.tmr[i].cnt = 16'h0000; // R19
            match_ev[i] = 1'b1; // R2
          end
          else
            s_next.tmr[i].cnt = s_reg.tmr[i].cnt + 16'h0001;
        end
        if (gate_fall[i])
          match_ev[i] = 1'b1; // R2 R20
      end
    end
    // joined pairs count as one 32-bit value
    for (int p = 1; p < 5; p += 2)
    begin
      if ((p == 1 && join_a) || (p == 3 && join_b))
      begin
        cnt32 = {s_reg.tmr[p+1].cnt, s_reg.tmr[p].cnt}; // R15
        per32 = {s_reg.tmr[p+1].per, s_reg.tmr[p].per}; // R16
        if (pre_wrap[p])
        begin
          if (cnt32 == per32)
          begin
            cnt32 = 32'h0; // R19
            match_ev[p+1] = 1'b1; // R14
          end
          else
            cnt32 = cnt32 + 32'h1;
        end
        if (gate_fall[p])
          match_ev[p+1] = 1'b1; // R14
        s_next.tmr[p].cnt = cnt32[15:0];
        s_next.tmr[p+1].cnt = cnt32[31:16];
      end
    end
    // when the first pair is joined its lower timer raises no event
    if (join_a)
      match_ev[1] = 1'b0;
    // bus access: one wait state, then answer
    s_next.bus_st = GPT_BUS_IDLE;
    if (bus_hit)
      s_next.bus_st = GPT_BUS_ACK;
    if (wr_fire && avs_byteenable[0] && avs_byteenable[1])
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (avs_address == `GPT_OFF_CON0 + 6'(4*i))
        begin
          s_next.tmr[i].con = wd & con_mask(i); // R11
          if (s_reg.tmr[i].con[`GPT_BIT_RUN])
            s_next.tmr[i].pre = 8'h00; // R10
        end
        if (avs_address == `GPT_OFF_CNT0 + 6'(4*i))
          s_next.tmr[i].cnt = wd;
        if (avs_address == `GPT_OFF_PER0 + 6'(4*i))
          s_next.tmr[i].per = wd; // R3
      end
    end
    // sticky flags: hardware set beats software clear
    if (wr_fire && avs_address == `GPT_OFF_FLAG && avs_byteenable[0])
      s_next.flag = s_reg.flag & ~avs_writedata[4:0];
    s_next.flag = s_next.flag | match_ev;
    // read mux; unmapped offsets read zero
    if (rd_fire)
    begin
      s_next.rdata = 32'h0;
      for (int i = 0; i < 5; i++)
      begin
        if (avs_address == `GPT_OFF_CON0 + 6'(4*i))
          s_next.rdata[15:0] = s_reg.tmr[i].con; // R11
        if (avs_address == `GPT_OFF_CNT0 + 6'(4*i))
          s_next.rdata[15:0] = s_reg.tmr[i].cnt;
        if (avs_address == `GPT_OFF_PER0 + 6'(4*i))
          s_next.rdata[15:0] = s_reg.tmr[i].per;
      end
      if (avs_address == `GPT_OFF_FLAG)
        s_next.rdata[4:0] = s_reg.flag;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      for (int i = 0; i < 5; i++)
        s_reg.tmr[i].per <= `GPT_PER_RESET;
    end
    else
      s_reg <= s_next;
  end

endmodule

// ===== hw/gpt_cfg.svh
// register offsets, field positions and reset values for the timer set
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH
`define GPT_ADDR_W 6
// control registers: standalone, then lower/upper per pair
`define GPT_OFF_CON0 6'h00
`define GPT_OFF_CON1 6'h04
`define GPT_OFF_CON2 6'h08
`define GPT_OFF_CON3 6'h0c
`define GPT_OFF_CON4 6'h10
// count registers
`define GPT_OFF_CNT0 6'h14
`define GPT_OFF_CNT1 6'h18
`define GPT_OFF_CNT2 6'h1c
`define GPT_OFF_CNT3 6'h20
`define GPT_OFF_CNT4 6'h24
// period registers
`define GPT_OFF_PER0 6'h28
`define GPT_OFF_PER1 6'h2c
`define GPT_OFF_PER2 6'h30
`define GPT_OFF_PER3 6'h34
`define GPT_OFF_PER4 6'h38
// sticky event flags, write one to clear
`define GPT_OFF_FLAG 6'h3c
// control bit positions
`define GPT_BIT_RUN 15
`define GPT_BIT_IDLE 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PS_HI 5
`define GPT_BIT_PS_LO 4
`define GPT_BIT_JOIN 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_CS 1
// implemented bits per control register
`define GPT_MASK_STANDALONE 16'ha076
`define GPT_MASK_LOWER 16'ha07a
`define GPT_MASK_UPPER 16'ha072
`define GPT_CON_RESET 16'h0000
`define GPT_PER_RESET 16'hffff
`endif

// ===== hw/gpt_pkg.sv
// types shared by the timer set
package gpt_pkg;
  typedef struct packed {
    logic [15:0] con;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [7:0] pre;
    logic gate_d;
  } gpt_timer_t;

  typedef enum logic [1:0] {
    GPT_BUS_IDLE = 2'b00,
    GPT_BUS_ACK = 2'b01
  } gpt_bus_st_t;

  typedef struct packed {
    gpt_timer_t [4:0] tmr;
    logic [2:0] ext_sync1;
    logic [2:0] ext_sync2;
    logic [2:0] ext_d;
    logic [4:0] flag;
    logic [31:0] rdata;
    gpt_bus_st_t bus_st;
  } gpt_state_t;
endpackage

// ===== verif/gpt_timer_set_monitor.sv
// assertion checker for the timer set ports
`timescale 1ns/1ps
module gpt_timer_set_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [4:0] event_flags,
  input wire logic conv_trigger
);
  logic join_reg;
  wire ack = !avs_waitrequest;
  wire rd = avs_read && ack;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // joined mode as software last wrote it
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      join_reg <= 1'b0;
    else if (avs_write && ack && avs_address == 6'h04)
      join_reg <= avs_writedata[3];
  flag_clear_a: assert property (|($past(event_flags) & ~event_flags) |->
    $past(avs_write && ack && avs_address == 6'h3c)) else $error("flag dropped unasked");
  con0_mask_a: assert property (rd && avs_address == 6'h00 |->
    (avs_readdata & ~32'ha076) == 32'h0) else $error("standalone spare bit set");
  con1_mask_a: assert property (rd && avs_address == 6'h04 |->
    (avs_readdata & ~32'ha07a) == 32'h0) else $error("lower spare bit set");
  con2_mask_a: assert property (rd && avs_address == 6'h08 |->
    (avs_readdata & ~32'ha072) == 32'h0) else $error("upper spare bit set");
  conv_flag_a: assert property (conv_trigger |=> event_flags[2]) else $error("trigger without flag");
  join_flag_a: assert property (join_reg && $past(join_reg, 2) |-> !$rose(event_flags[1]))
    else $error("lower flag while joined");
  rst_flags_a: assert property ($fell(rst) |-> event_flags == 5'h0) else $error("flags not reset");
  req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> ack)
    else $error("late answer");
endmodule
bind gpt_timer_set gpt_timer_set_monitor mon (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .event_flags(event_flags),
  .conv_trigger(conv_trigger));

// ===== verif/gpt_pin_model.sv
// far-side model of the external clock and gate pin
`timescale 1ns/1ps
module gpt_pin_model (
  input wire logic clk_sys,
  output logic pin
);
  // rests low between bursts, as an idle clock does
  initial pin = 1'b0;
  // n high pulses; rising edges count, a falling edge closes a gate
  task automatic drive(input int n, input int hi, input int lo);
    repeat (n)
    begin
      pin <= 1'b1;
      repeat (hi) @(posedge clk_sys);
      pin <= 1'b0;
      repeat (lo) @(posedge clk_sys);
    end
  endtask
endmodule

// ===== verif/gpt_timer_set_tb.sv
// self-checking bench for the timer set
`timescale 1ns/1ps
module gpt_timer_set_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cpu_idle = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] event_flags;
  logic conv_trigger;
  logic pin;
  logic conv_seen = 1'b0;
  logic [31:0] q;
  logic [31:0] d;
  logic [15:0] mask [5] = '{16'ha076, 16'ha07a, 16'ha072, 16'ha07a, 16'ha072};
  int fails = 0;
  int num_checks = 0;
  int seed = 32'hbd5c9eab;
  always #5 clk_sys = ~clk_sys;
  // remember any converter trigger pulse
  always @(posedge clk_sys)
    if (conv_trigger === 1'b1)
      conv_seen <= 1'b1;
  gpt_timer_set uut (.clk_sys(clk_sys), .rst(rst), .cpu_idle(cpu_idle), .ext_clock_pin({2'b00, pin}),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_flags(event_flags), .conv_trigger(conv_trigger));
  gpt_pin_model pm (.clk_sys(clk_sys), .pin(pin));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one bus cycle; waitrequest and read data sampled at the rising edge itself
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task w(input logic [5:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task rc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // stop, zero and restart the standalone timer with flags cleared
  task arm(input logic [31:0] con);
    w(6'h00, 32'h0);
    w(6'h14, 32'h0);
    w(6'h3c, 32'h1f);
    w(6'h00, con);
  endtask
  function logic near(logic [31:0] a, int e, int tol);
    return (int'(a) - e <= tol) && (e - int'(a) <= tol);
  endfunction
  function int scaled(int k, int ps);
    return k / (ps == 3 ? 256 : 1 << (3 * ps));
  endfunction
  task wrap_up();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rc("per", 6'(40 + i * 4), 32'hffff);
      d = $random(seed) & 32'h7fff;
      w(6'(i * 4), d);
      rc("con", 6'(i * 4), d & mask[i]);
      w(6'(i * 4), 32'h0);
    end
    for (int ps = 0; ps < 4; ps++)
    begin
      arm(32'h8000 | 32'(ps << 4));
      repeat (512) @(posedge clk_sys);
      w(6'h00, 32'h0);
      bus(1'b0, 6'h14, 32'h0);
      chk("scaled", near(q, scaled(514, ps), ps == 0 ? 3 : 1), 1);
    end
    // halted while idle; cpu_idle drops back low only after the read
    cpu_idle <= 1'b1;
    arm(32'ha000);
    repeat (50) @(posedge clk_sys);
    rc("idle", 6'h14, 32'h0);
    cpu_idle <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      arm(s ? 32'h8002 : 32'h8006);
      pm.drive(20, 3, 3);
      rc("edges", 6'h14, 32'd20);
    end
    arm(32'h8040);
    pm.drive(1, 100, 4);
    bus(1'b0, 6'h14, 32'h0);
    chk("gated", near(q, 100, 3), 1);
    rc("gate flag", 6'h3c, 32'h1);
    w(6'h28, 32'h9);
    conv_seen <= 1'b0;
    arm(32'h8000);
    repeat (30) @(posedge clk_sys);
    bus(1'b0, 6'h14, 32'h0);
    chk("wrap", q <= 32'h9, 1);
    rc("match", 6'h3c, 32'h1);
    chk("trig", conv_seen, 0);
    // joined pair; upper left running to show it is ignored
    w(6'h00, 32'h0);
    w(6'h04, 32'h8);
    w(6'h08, 32'h8000);
    w(6'h2c, 32'h20);
    w(6'h30, 32'h2);
    w(6'h18, 32'hfff0);
    w(6'h3c, 32'h1f);
    w(6'h04, 32'h8008);
    repeat (60) @(posedge clk_sys);
    w(6'h04, 32'h8);
    rc("high", 6'h1c, 32'h1);
    rc("long", 6'h3c, 32'h0);
    w(6'h08, 32'h0);
    w(6'h18, 32'h0);
    w(6'h1c, 32'h0);
    w(6'h30, 32'h0);
    w(6'h2c, 32'h10);
    w(6'h3c, 32'h1f);
    conv_seen <= 1'b0;
    w(6'h04, 32'h8008);
    repeat (60) @(posedge clk_sys);
    w(6'h04, 32'h8);
    rc("joined", 6'h3c, 32'h4);
    chk("trig", conv_seen, 1);
    wrap_up();
  end
  // hang guard, well past the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
endmodule
